// [src/sls_regs.svh]
// Constants of the speed lock supervisor: offsets, fields, reset values and timing
// What this block does
// RULE1: Internal control ticks come from an on-chip 5.8 MHz clock, no parts needed.
// RULE2: Two-bit stored setting picks pre-divider 3, 4, 6 or 8 with range high.
// RULE3: Total reference division is 1024 times pre-divider, default 8192 or 16384.
// RULE4: Range input low doubles the reference division, live, without reprogramming.
// RULE5: Lock detector counts reference clocks between rising speed pulse edges.
// RULE6: Lock is declared while speed frequency is within five percent of target.
// RULE7: Lock indicator output is driven low while lock is detected.
// RULE8: Speed outside the window raises an out-of-lock signal to the timer.
// RULE9: While out of lock the lock timer advances once per timer oscillator period.
// RULE10: Out of lock lasting 1023 timer counts issues a lock timeout to shutdown.
// RULE11: After undervoltage ends, power-up clear waits three 20 kHz ticks, about 150 us; the ticks here run at about 22.7 kHz, about 132 us.
// RULE12: Device stays cleared until the charge pump has reached its good level.
// RULE13: Overcurrent or lock timeout latches the clear state with gate drives off.
// RULE14: Controller releases shutdown by pulsing run/stop high then low, or cycles power.
// RULE15: A condition still present after run/stop cycling latches shutdown again.
// RULE16: Run/stop high or the supply clear resets the lock timer counter.
// RULE17: Supply undervoltage forces a global clear of the logic.
// RULE18: Run/stop high holds gate drives off and lock and timer logic cleared.
// RULE19: Overcurrent and pump undervoltage act after deglitch; only overcurrent latches.
`ifndef SLS_REGS_SVH
`define SLS_REGS_SVH
// Clock rates in kHz
`define SLS_SYS_KHZ        20000
`define SLS_INT_OSC_KHZ    5800
`define SLS_PHASE_STEP     (`SLS_INT_OSC_KHZ / 100)
`define SLS_PHASE_MOD      (`SLS_SYS_KHZ / 100)
// Power-up clear: 5.8 MHz divided by 255, three ticks
`define SLS_SLOW_DIV       255
`define SLS_PWRUP_TICKS    3
// Deglitch blanking time in ns, least time rounds up
`define SLS_DEGLITCH_NS    3700
`define SLS_DEGLITCH_CYC   ((`SLS_DEGLITCH_NS * `SLS_SYS_KHZ + 999999) / 1000000)
// Reference division and lock window
`define SLS_REF_MULT       1024
`define SLS_WIN_NUM_LO     19
`define SLS_WIN_NUM_HI     21
`define SLS_WIN_DEN        20
`define SLS_TIMEOUT_CNT    1023
// Pin input bit positions in the synchroniser vector
`define SLS_PIN_REF        0
`define SLS_PIN_TMR        1
`define SLS_PIN_SPD        2
`define SLS_PIN_RNG        3
`define SLS_PIN_RUN        4
`define SLS_PIN_UVLO       5
`define SLS_PIN_PUV        6
`define SLS_PIN_OC         7
`define SLS_PIN_CNT        8
// Register offsets (byte addresses)
`define SLS_OFS_CTRL       8'h00
`define SLS_OFS_STATUS     8'h04
`define SLS_OFS_MASK       8'h08
`define SLS_OFS_STATE      8'h0C
// Reset values
`define SLS_CTRL_RESET     2'h3
`define SLS_MASK_RESET     4'h0
// Status and mask bit positions
`define SLS_EV_TIMEOUT     0
`define SLS_EV_OVERCUR     1
`define SLS_EV_LOCKED      2
`define SLS_EV_UNLOCKED    3
`define SLS_EV_CNT         4
`endif

// [src/sls_pkg.sv]
// Types shared by the speed lock supervisor
package sls_pkg;
  // One register bus request, sampled on each rising clock edge
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } sls_bus_req_t;

  // Filtered view of the supervised conditions
  typedef struct packed {
    logic run;
    logic uvlo;
    logic pump_uv;
    logic overcur;
  } sls_cond_t;

  // Power-up clear sequencer
  typedef enum logic [1:0] {
    SLS_PWRUP_HOLD,
    SLS_PWRUP_COUNT,
    SLS_PWRUP_DONE
  } sls_pwrup_state_t;
endpackage : sls_pkg

// [src/sls_supervisor.sv]
// Speed lock supervisor: reference divider, lock detector, lock timer, clear and shutdown
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "sls_regs.svh"
module sls_supervisor #(
  parameter int CNT_W = 16
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire sls_pkg::sls_bus_req_t bus_i,
  output logic [15:0]                rd_data_o,
  input  wire logic                  reference_osc_input_i,
  input  wire logic                  lock_timer_capacitor_i,
  input  wire logic                  speed_pulse_i,
  input  wire logic                  speed_range_select_i,
  input  wire logic                  run_stop_i,
  input  wire logic                  vdd_uvlo_i,
  input  wire logic                  pump_undervoltage_i,
  input  wire logic                  overcurrent_i,
  output logic                       lock_indicator_o,
  output logic                       lock_timeout_o,
  output logic                       power_up_clear_o,
  output logic                       gate_enable_o,
  output logic                       target_pulse_o,
  output logic                       irq_o
);
  import sls_pkg::*;

  // Elaboration check: the upper window bound needs 15 bits, more than 24 only wastes area
  if (CNT_W < 15 || CNT_W > 24) begin : g_cnt_w_check
    $error("CNT_W must hold the longest window bound");
  end

  // Pin synchroniser, three stages; a change counts once stages two and three agree
  logic [`SLS_PIN_CNT-1:0] s1_q, s2_q, s3_q, filt_q, filt_prev_q;
  logic [`SLS_PIN_CNT-1:0] pins;
  assign pins = {overcurrent_i, pump_undervoltage_i, vdd_uvlo_i, run_stop_i,
                 speed_range_select_i, speed_pulse_i, lock_timer_capacitor_i, reference_osc_input_i};

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1_q        <= '0;
      s2_q        <= '0;
      s3_q        <= '0;
      filt_q      <= '0;
      filt_prev_q <= '0;
    end else begin
      s1_q        <= pins;
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      filt_q      <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
      filt_prev_q <= filt_q;
    end
  end

  // Edges and levels seen by the rest of the block
  logic      ref_rise, tmr_rise, spd_rise, run_fall;
  sls_cond_t cond;
  assign ref_rise     = filt_q[`SLS_PIN_REF] & ~filt_prev_q[`SLS_PIN_REF];
  assign tmr_rise     = filt_q[`SLS_PIN_TMR] & ~filt_prev_q[`SLS_PIN_TMR];
  assign spd_rise     = filt_q[`SLS_PIN_SPD] & ~filt_prev_q[`SLS_PIN_SPD];
  assign run_fall     = ~filt_q[`SLS_PIN_RUN] & filt_prev_q[`SLS_PIN_RUN];
  assign cond.run     = filt_q[`SLS_PIN_RUN];
  assign cond.uvlo    = filt_q[`SLS_PIN_UVLO];
  assign cond.pump_uv = filt_q[`SLS_PIN_PUV];
  assign cond.overcur = filt_q[`SLS_PIN_OC];

  // Lock and timer logic is held cleared by run/stop or the supply clear
  logic lock_clr;
  assign lock_clr = cond.run | cond.uvlo;  // see RULE18, see RULE17

  // Software registers
  logic [1:0]             ctrl_q;
  logic [`SLS_EV_CNT-1:0] status_q, mask_q, events;

  // Pre-divider from the stored setting; range low doubles it on the fly
  logic [4:0]       prediv;
  logic [CNT_W-1:0] total_div;
  always_comb begin
    case (ctrl_q)  // see RULE2
      2'h0:    prediv = 5'h03;
      2'h1:    prediv = 5'h04;
      2'h2:    prediv = 5'h06;
      default: prediv = 5'h08;
    endcase
    if (!filt_q[`SLS_PIN_RNG]) begin
      prediv = {prediv[3:0], 1'b0};  // see RULE4
    end
  end
  assign total_div = CNT_W'(prediv * `SLS_REF_MULT);  // see RULE3

  // On-chip 5.8 MHz tick made by a phase accumulator on the 20 MHz clock
  // One bit above the modulus, so the sum of phase and step can never wrap and lose a tick
  logic [8:0] phase_q;
  logic       int_tick;
  assign int_tick = (phase_q + 9'(`SLS_PHASE_STEP)) >= 9'(`SLS_PHASE_MOD);
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      phase_q <= '0;
    end else if (int_tick) begin
      phase_q <= phase_q + 9'(`SLS_PHASE_STEP) - 9'(`SLS_PHASE_MOD);  // see RULE1
    end else begin
      phase_q <= phase_q + 9'(`SLS_PHASE_STEP);
    end
  end

  // About 22.7 kHz tick: internal tick divided by 255
  logic [7:0] slow_cnt_q;
  logic       slow_tick;
  assign slow_tick = int_tick && (slow_cnt_q == 8'(`SLS_SLOW_DIV - 1));
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      slow_cnt_q <= '0;
    end else if (slow_tick) begin
      slow_cnt_q <= '0;
    end else if (int_tick) begin
      slow_cnt_q <= slow_cnt_q + 8'h01;
    end
  end

  // Power-up clear: waits for the supply, then counts slow ticks
  sls_pwrup_state_t pwrup_q;
  logic [1:0]       pwrup_cnt_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pwrup_q     <= SLS_PWRUP_HOLD;
      pwrup_cnt_q <= '0;
    end else if (cond.uvlo) begin
      pwrup_q     <= SLS_PWRUP_HOLD;  // see RULE17
      pwrup_cnt_q <= '0;
    end else begin
      case (pwrup_q)
        SLS_PWRUP_HOLD: begin
          pwrup_q     <= SLS_PWRUP_COUNT;
          pwrup_cnt_q <= '0;
        end
        SLS_PWRUP_COUNT: begin
          if (slow_tick) begin
            pwrup_cnt_q <= pwrup_cnt_q + 2'h1;
            if (pwrup_cnt_q == 2'(`SLS_PWRUP_TICKS - 1)) begin
              pwrup_q <= SLS_PWRUP_DONE;  // see RULE11
            end
          end
        end
        SLS_PWRUP_DONE: pwrup_q <= SLS_PWRUP_DONE;
        default:        pwrup_q <= SLS_PWRUP_HOLD;
      endcase
    end
  end

  // Charge pump must be seen good once after power-up before release
  logic pump_seen_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || cond.uvlo) begin
      pump_seen_q <= 1'b0;
    end else if (!cond.pump_uv) begin
      pump_seen_q <= 1'b1;  // see RULE12
    end
  end

  // Deglitch of overcurrent and pump undervoltage; short spikes are ignored
  localparam int DG_W = $clog2(`SLS_DEGLITCH_CYC + 1);
  logic [1:0]      dg_in, dg_q;
  logic [DG_W-1:0] dg_cnt_q [2];
  assign dg_in = {cond.pump_uv, cond.overcur};
  for (genvar g = 0; g < 2; g++) begin : g_deglitch
    always_ff @(posedge clock_i) begin
      if (!rst_n_i || !dg_in[g]) begin
        dg_cnt_q[g] <= '0;
        dg_q[g]     <= 1'b0;
      end else if (dg_cnt_q[g] == DG_W'(`SLS_DEGLITCH_CYC)) begin
        dg_q[g] <= 1'b1;  // see RULE19
      end else begin
        dg_cnt_q[g] <= dg_cnt_q[g] + 1'b1;
      end
    end
  end

  // Reference divider: one target pulse per total division of the oscillator
  logic [CNT_W-1:0] div_cnt_q;
  logic             target_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      div_cnt_q <= '0;
      target_q  <= 1'b0;
    end else begin
      target_q <= 1'b0;
      if (ref_rise) begin
        if (div_cnt_q >= total_div - 1'b1) begin
          div_cnt_q <= '0;  // see RULE3
          target_q  <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 1'b1;
        end
      end
    end
  end

  // Lock window on the measured period, bounds follow the live division
  logic [CNT_W+4:0] win_lo_w, win_hi_w;
  logic [CNT_W-1:0] win_lo, win_hi;
  assign win_lo_w = ((CNT_W+5)'(total_div) * (CNT_W+5)'(`SLS_WIN_NUM_LO)) / (CNT_W+5)'(`SLS_WIN_DEN);
  assign win_hi_w = ((CNT_W+5)'(total_div) * (CNT_W+5)'(`SLS_WIN_NUM_HI)) / (CNT_W+5)'(`SLS_WIN_DEN);
  assign win_lo   = win_lo_w[CNT_W-1:0];
  assign win_hi   = win_hi_w[CNT_W-1:0];

  // Period counter of reference clocks between speed pulse rising edges
  logic [CNT_W-1:0] per_cnt_q;
  logic             per_valid_q, locked_q, in_window, too_slow;
  assign in_window = (per_cnt_q >= win_lo) && (per_cnt_q <= win_hi);  // see RULE6
  assign too_slow  = per_cnt_q > win_hi;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || lock_clr) begin
      per_cnt_q   <= '0;
      per_valid_q <= 1'b0;
    end else if (spd_rise) begin
      per_cnt_q   <= CNT_W'(ref_rise);  // see RULE5
      per_valid_q <= 1'b1;
    end else if (ref_rise && !(&per_cnt_q)) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // Lock decision at each speed edge after the first since the clear; a stalled motor drops lock without waiting
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || lock_clr) begin
      locked_q <= 1'b0;
    end else if (spd_rise && per_valid_q) begin
      locked_q <= in_window;
    end else if (too_slow) begin
      locked_q <= 1'b0;
    end
  end

  // Out of lock feeds the lock timer
  logic out_of_lock;
  assign out_of_lock = ~locked_q & ~lock_clr;  // see RULE8

  // Lock timer counts timer oscillator periods while out of lock
  logic [9:0] tmr_cnt_q;
  logic       timeout_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || lock_clr) begin
      tmr_cnt_q <= '0;  // see RULE16
      timeout_q <= 1'b0;
    end else if (!out_of_lock) begin
      tmr_cnt_q <= '0;
    end else if (tmr_rise && !timeout_q) begin
      tmr_cnt_q <= tmr_cnt_q + 10'h001;  // see RULE9
      if (tmr_cnt_q == 10'(`SLS_TIMEOUT_CNT - 1)) begin
        timeout_q <= 1'b1;  // see RULE10
      end
    end
  end

  // Shutdown latch; set wins over the release so a standing fault relatches
  logic shut_q, shut_set;
  assign shut_set = dg_q[0] | timeout_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shut_q <= 1'b0;
    end else if (shut_set) begin
      shut_q <= 1'b1;  // see RULE13, see RULE15
    end else if (run_fall || cond.uvlo) begin
      shut_q <= 1'b0;  // see RULE14
    end
  end

  // Clear state and drive enable, both registered outputs
  logic clear_d, clear_q, gate_q, lock_ind_q;
  assign clear_d = cond.uvlo | cond.run | (pwrup_q != SLS_PWRUP_DONE) | ~pump_seen_q | shut_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      clear_q    <= 1'b1;
      gate_q     <= 1'b0;
      lock_ind_q <= 1'b1;
    end else begin
      clear_q    <= clear_d;
      gate_q     <= ~clear_d & ~dg_q[1] & ~shut_set;  // see RULE18, see RULE19
      lock_ind_q <= ~locked_q;  // see RULE7
    end
  end

  // Events for the interrupt status; lock gained and lost are edges of the decision
  logic locked_prev_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      locked_prev_q <= 1'b0;
    end else begin
      locked_prev_q <= locked_q;
    end
  end
  assign events[`SLS_EV_TIMEOUT]  = timeout_q & ~shut_q;
  assign events[`SLS_EV_OVERCUR]  = dg_q[0] & ~shut_q;
  assign events[`SLS_EV_LOCKED]   = locked_q & ~locked_prev_q;
  assign events[`SLS_EV_UNLOCKED] = ~locked_q & locked_prev_q;

  // Write decode
  logic wr_ctrl, wr_status, wr_mask;
  assign wr_ctrl   = bus_i.wr && (bus_i.addr == `SLS_OFS_CTRL);
  assign wr_status = bus_i.wr && (bus_i.addr == `SLS_OFS_STATUS);
  assign wr_mask   = bus_i.wr && (bus_i.addr == `SLS_OFS_MASK);

  // Control and mask registers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_q <= `SLS_CTRL_RESET;
      mask_q <= `SLS_MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= bus_i.wdata[1:0];
      end
      if (wr_mask) begin
        mask_q <= bus_i.wdata[`SLS_EV_CNT-1:0];
      end
    end
  end

  // Sticky status, write one to clear; a new event in the same cycle wins
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(wr_status ? bus_i.wdata[`SLS_EV_CNT-1:0] : '0)) | events;
    end
  end

  // Read data stands one cycle after the strobe; unmapped offsets read zero
  logic [15:0] rd_q;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !bus_i.rd) begin
      rd_q <= '0;
    end else begin
      case (bus_i.addr)
        `SLS_OFS_CTRL:   rd_q <= {14'h0000, ctrl_q};
        `SLS_OFS_STATUS: rd_q <= {12'h000, status_q};
        `SLS_OFS_MASK:   rd_q <= {12'h000, mask_q};
        `SLS_OFS_STATE:  rd_q <= {tmr_cnt_q, filt_q[`SLS_PIN_RNG], gate_q, clear_q, shut_q, timeout_q, locked_q};
        default:         rd_q <= '0;
      endcase
    end
  end

  // Outputs
  assign rd_data_o        = rd_q;
  assign lock_indicator_o = lock_ind_q;
  assign lock_timeout_o   = timeout_q;
  assign power_up_clear_o = clear_q;
  assign gate_enable_o    = gate_q;
  assign target_pulse_o   = target_q;
  assign irq_o            = |(status_q & mask_q);

  // Pre-divider selection for the lowest code with range high
  prediv_map_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)  // see RULE2
    (ctrl_q == 2'h0 && filt_q[`SLS_PIN_RNG]) |-> (total_div == CNT_W'(3 * `SLS_REF_MULT)))
    else $error("pre-divider code 0 did not give 3072");

  // Range low doubles the division
  range_double_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)  // see RULE4
    (ctrl_q == 2'h3 && !filt_q[`SLS_PIN_RNG]) |-> (total_div == CNT_W'(16 * `SLS_REF_MULT)))
    else $error("range low did not double the division");

  // Divider wraps with a target pulse
  div_wrap_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)  // see RULE3
    (ref_rise && div_cnt_q == total_div - 1'b1) |=> (target_q && div_cnt_q == '0))
    else $error("reference divider did not wrap");

  // Measured period in window gives lock
  lock_window_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)  // see RULE6
    (spd_rise && per_valid_q && in_window && !lock_clr) |=> locked_q ##1 !lock_indicator_o)
    else $error("in-window period did not lock");

  // Timer reaches its final count and times out
  timer_out_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)  // see RULE10
    (tmr_rise && out_of_lock && tmr_cnt_q == 10'(`SLS_TIMEOUT_CNT - 1)) |=> timeout_q ##1 shut_q)
    else $error("lock timeout did not latch shutdown");

  // Run/stop high clears the timer and turns the drives off
  run_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)  // see RULE16, see RULE18
    cond.run |=> (tmr_cnt_q == '0 && !locked_q && !gate_enable_o))
    else $error("run/stop high left timer or drives active");

  // Overcurrent persisting past blanking latches shutdown
  oc_latch_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)  // see RULE13, see RULE19
    $rose(dg_q[0]) |=> shut_q ##1 (!gate_enable_o && power_up_clear_o))
    else $error("overcurrent did not latch shutdown");

  // Supply undervoltage release still holds clear for the first eight cycles of the power-up wait
  pwrup_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)  // see RULE11, see RULE17
    $fell(cond.uvlo) |-> power_up_clear_o [*8])
    else $error("clear released too early after undervoltage");

  // Pump not yet good keeps the device cleared
  pump_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)  // see RULE12
    !pump_seen_q |=> power_up_clear_o)
    else $error("released before pump was good");
endmodule : sls_supervisor

// [bench/sls_far_side.sv]
// Far-side model: reference crystal, speed sensor and lock timer oscillator
`timescale 1ns/10ps
module sls_far_side #(
  parameter int SPD_PER = 24576,
  parameter int SPD_OFS = 5000
) (
  input  wire logic clock_i,
  input  wire logic tmr_run_i,
  output logic      ref_osc_o = 1'b0,
  output logic      speed_o   = 1'b0,
  output logic      tmr_osc_o = 1'b0
);
  int unsigned ref_cnt_q = 0;
  int unsigned spd_cnt_q = SPD_PER - SPD_OFS;
  int unsigned tmr_cnt_q = 0;
  // Crystal runs free; eight clocks a period keeps each level past the pin filter
  always @(posedge clock_i) begin
    ref_cnt_q <= ref_cnt_q + 1;
    ref_osc_o <= ref_cnt_q[2];
  end
  // Speed sensor: short high pulse once per period, 3072 reference periods apart
  always @(posedge clock_i) begin
    spd_cnt_q <= spd_cnt_q + 1;
    speed_o   <= (spd_cnt_q % SPD_PER) < 100;
  end
  // Timer oscillator only swings when asked, else it would time out before first lock
  always @(posedge clock_i) begin
    tmr_cnt_q <= tmr_run_i ? tmr_cnt_q + 1 : 0;
    tmr_osc_o <= tmr_run_i & tmr_cnt_q[2];
  end
endmodule : sls_far_side

// [bench/speed_lock_supervisor_test.sv]
// Self-checking bench for the speed lock supervisor
`timescale 1ns/10ps
`include "sls_regs.svh"
module speed_lock_supervisor_test;
  import sls_pkg::*;
  localparam int LCK = 0, TMO = 1, CLR = 2, GATE = 3, TGT = 4, IRQ = 5;
  logic         clock_i = 1'b0;
  logic         rst_n_i = 1'b0;
  sls_bus_req_t bus_q   = '0;
  logic [15:0]  rd_data_o;
  logic         ref_w, tmr_w, spd_w;
  logic         range_q = 1'b1, run_q = 1'b0, uvlo_q = 1'b0, puv_q = 1'b0, oc_q = 1'b0, tmr_q = 1'b0;
  logic         lock_indicator_o, lock_timeout_o, power_up_clear_o, gate_enable_o, target_pulse_o, irq_o;
  logic [15:0]  exp_q[$];
  logic [15:0]  msk_q[$];
  logic         rd_seen = 1'b0;
  int           err_total = 0, compares = 0, n, t0;
  wire  [5:0]   outs = {irq_o, target_pulse_o, gate_enable_o, power_up_clear_o, lock_timeout_o, lock_indicator_o};

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  sls_supervisor sls_supervisor_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .bus_i(bus_q), .rd_data_o(rd_data_o),
    .reference_osc_input_i(ref_w), .lock_timer_capacitor_i(tmr_w), .speed_pulse_i(spd_w),
    .speed_range_select_i(range_q), .run_stop_i(run_q), .vdd_uvlo_i(uvlo_q),
    .pump_undervoltage_i(puv_q), .overcurrent_i(oc_q), .lock_indicator_o(lock_indicator_o),
    .lock_timeout_o(lock_timeout_o), .power_up_clear_o(power_up_clear_o),
    .gate_enable_o(gate_enable_o), .target_pulse_o(target_pulse_o), .irq_o(irq_o)
  );
  sls_far_side sls_far_side_inst (
    .clock_i(clock_i), .tmr_run_i(tmr_q), .ref_osc_o(ref_w), .speed_o(spd_w), .tmr_osc_o(tmr_w)
  );

  function automatic int cyc();
    return int'($time / 50);
  endfunction : cyc

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Output level, sampled after the edge's updates have landed
  task automatic lvl(input int s, input logic v);
    #1;
    chk(16'(outs[s]), 16'(v));
  endtask : lvl

  // Bounded wait; n returns the cycles spent
  task automatic wait_out(input int s, input logic v, input int lim);
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (outs[s] !== v && n < lim);
    if (outs[s] !== v) begin
      chk(16'(outs[s]), 16'(v));
      give_verdict();
    end
  endtask : wait_out

  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    bus_q <= '0;
  endtask : bus_wr

  // The expectation is queued here and judged by the read monitor
  task automatic bus_rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clock_i);
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock_i);
    bus_q <= '0;
    @(posedge clock_i);
  endtask : bus_rd

  // Read data stand only in the cycle after the strobe, so they are judged there
  always @(posedge clock_i) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(rd_data_o & msk_q.pop_front(), exp_q.pop_front());
    end
    rd_seen <= bus_q.rd;
  end

  // Main sequence
  initial begin
    void'($urandom(32'hF578EA2E));
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t0 = cyc();
    lvl(CLR, 1'b1);
    lvl(GATE, 1'b0);
    bus_rd(`SLS_OFS_CTRL, 16'h0003, 16'h0003);
    bus_rd(`SLS_OFS_MASK, 16'h0000, 16'h000F);
    bus_rd(`SLS_OFS_STATUS, 16'h0000, 16'h000F);
    bus_rd(8'h10, 16'h0000, 16'hFFFF);
    for (int k = 3; k >= 0; k--) begin
      bus_wr(`SLS_OFS_CTRL, (16'($urandom) & 16'hFFFC) | 16'(k));
      bus_rd(`SLS_OFS_CTRL, 16'(k), 16'h0003);
    end
    n = $urandom % 16;
    bus_wr(`SLS_OFS_MASK, 16'(n));
    bus_rd(`SLS_OFS_MASK, 16'(n), 16'h000F);
    bus_wr(`SLS_OFS_MASK, 16'h0004);
    wait_out(CLR, 1'b0, 3000);
    chk_rng(cyc() - t0, 1750, 2710);
    lvl(GATE, 1'b1);
    $display("reset, registers and power-up clear done");
    // Prescaler code 0 with range high: one target pulse per 3072 reference periods of 8 clocks
    wait_out(TGT, 1'b1, 25000);
    t0 = cyc();
    wait_out(TGT, 1'b1, 25000);
    chk_rng(cyc() - t0, 24576, 24576);
    lvl(LCK, 1'b0);
    lvl(IRQ, 1'b1);
    bus_rd(`SLS_OFS_STATUS, 16'h0004, 16'h000F);
    bus_wr(`SLS_OFS_STATUS, 16'h0004);
    repeat (2) @(posedge clock_i);
    lvl(IRQ, 1'b0);
    $display("divider and lock done");
    // Range low doubles the target count, so the same speed falls out of the window
    @(posedge clock_i);
    range_q <= 1'b0;
    repeat (6) @(posedge clock_i);
    bus_rd(`SLS_OFS_STATE, 16'h0000, 16'h0020);
    wait_out(LCK, 1'b1, 26000);
    bus_rd(`SLS_OFS_STATUS, 16'h0008, 16'h000F);
    // Default code with range low gives the longest division; still far from this speed
    bus_wr(`SLS_OFS_CTRL, 16'h0003);
    bus_rd(`SLS_OFS_CTRL, 16'h0003, 16'h0003);
    $display("range and lock loss done");
    @(posedge clock_i);
    tmr_q <= 1'b1;
    t0 = cyc();
    wait_out(TMO, 1'b1, 9000);
    chk_rng(cyc() - t0, 8150, 8240);
    wait_out(GATE, 1'b0, 4);
    // The clear output follows the shutdown latch one cycle after the drives drop
    @(posedge clock_i);
    lvl(CLR, 1'b1);
    @(posedge clock_i);
    tmr_q <= 1'b0;
    bus_rd(`SLS_OFS_STATUS, 16'h0009, 16'h000F);
    lvl(IRQ, 1'b0);
    @(posedge clock_i);
    run_q <= 1'b1;
    repeat (8) @(posedge clock_i);
    lvl(TMO, 1'b0);
    lvl(GATE, 1'b0);
    bus_rd(`SLS_OFS_STATE, 16'h0000, 16'hFFC1);
    run_q <= 1'b0;
    wait_out(GATE, 1'b1, 20);
    $display("lock timer and release done");
    // A blip shorter than the blanking time must be ignored
    @(posedge clock_i);
    oc_q <= 1'b1;
    repeat (10 + $urandom % 50) @(posedge clock_i);
    oc_q <= 1'b0;
    repeat (100) @(posedge clock_i);
    lvl(GATE, 1'b1);
    @(posedge clock_i);
    oc_q <= 1'b1;
    t0 = cyc();
    wait_out(GATE, 1'b0, 100);
    chk_rng(cyc() - t0, 74, 84);
    bus_rd(`SLS_OFS_STATUS, 16'h000B, 16'h000F);
    run_q <= 1'b1;
    repeat (6) @(posedge clock_i);
    run_q <= 1'b0;
    repeat (120) @(posedge clock_i);
    lvl(GATE, 1'b0);
    bus_rd(`SLS_OFS_STATE, 16'h0004, 16'h0004);
    oc_q  <= 1'b0;
    run_q <= 1'b1;
    repeat (6) @(posedge clock_i);
    run_q <= 1'b0;
    wait_out(GATE, 1'b1, 30);
    $display("overcurrent done");
    @(posedge clock_i);
    puv_q <= 1'b1;
    t0 = cyc();
    wait_out(GATE, 1'b0, 100);
    chk_rng(cyc() - t0, 74, 84);
    @(posedge clock_i);
    puv_q <= 1'b0;
    wait_out(GATE, 1'b1, 100);
    bus_rd(`SLS_OFS_STATE, 16'h0000, 16'h0004);
    $display("pump undervoltage done");
    // A bad pump holds the clear even after the power-up count has run out
    @(posedge clock_i);
    uvlo_q <= 1'b1;
    puv_q  <= 1'b1;
    wait_out(CLR, 1'b1, 10);
    lvl(GATE, 1'b0);
    @(posedge clock_i);
    uvlo_q <= 1'b0;
    repeat (2800) @(posedge clock_i);
    lvl(CLR, 1'b1);
    puv_q <= 1'b0;
    wait_out(CLR, 1'b0, 200);
    $display("supply clear done");
    give_verdict();
  end
endmodule : speed_lock_supervisor_test
